//--- design/mission_control.sv
// mission control command interpreter: forced conversion, start and stop mission
// assumes a slot layer on the same clock that delivers function bytes and asks to pull low
`timescale 1ns/1ps

module mission_control
  import mc_pkg::*;
#(
  parameter int CONV_LIMIT = CONV_CYCLES,
  parameter int TICK_LEN   = TICK_CYCLES
) (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        resetn,
  // wishbone slave
  input  wire logic        wbCyc,
  input  wire logic        wbStb,
  input  wire logic        wbWe,
  input  wire logic [7:0]  wbAdr,
  input  wire logic [3:0]  wbSel,
  input  wire logic [31:0] wbDatW,
  output logic      [31:0] wbDatR,
  output logic             wbAck,
  // function bytes from the slot layer
  input  wire logic        fnByteValid,
  input  wire logic [7:0]  fnByte,
  input  wire logic        fnFirst,
  input  wire logic        busReset,
  // pull requests from the slot layer
  input  wire logic        slotPullLow,
  input  wire logic        presencePull,
  // open drain data pin
  input  wire logic        dqIn,
  output logic             dqOut,
  output logic             dqOen,
  output logic             dqSample,
  // temperature sensor
  output logic             convStart,
  input  wire logic        sensorValid,
  input  wire logic [15:0] sensorData,
  // rest of the unit
  input  wire logic        tempAlarm,
  input  wire logic        clearDone,
  output logic             logWrite,
  output logic      [15:0] logData,
  output logic             accessBlocked,
  output logic             pagesWritable,
  output logic             missionActive,
  output logic             awaitingAlarm
);
  typedef struct packed {
    cmd_state_t  cs;
    logic [7:0]  cmd;
    logic [3:0]  nb;
    mission_t    mph;
    logic        awaiting;
    logic        logCleared;
    logic        pwEn;
    logic        alarmStart;
    logic [63:0] pw;
    logic [31:0] delay;
    logic [31:0] period;
    logic [31:0] stamp;
    logic [31:0] count;
    logic [31:0] uptime;
    logic [31:0] convCnt;
    logic [15:0] temp;
    logic        convBusy;
    logic        convStart;
    logic        countIt;
    logic        logIt;
    logic        logWrite;
    logic        ack;
    logic [31:0] rdata;
    logic [1:0]  dqSync;
  } ctl_t;

  localparam ctl_t CTL_RST = '{cs: CS_IDLE, mph: MS_OFF, period: PERIOD_RST,
                               delay: DELAY_RST, default: '0};

  ctl_t st_r;
  ctl_t st_nxt;
  mc_link_if lk ();

  logic byteIn;
  logic pwOk;
  logic dummyIn;
  logic startOk;
  logic stopOk;
  logic wr;

  initial begin
    if (CONV_LIMIT < 1) $error("mission_control needs a conversion limit of one cycle or more");
  end

  pw_matcher #(.BYTES(PW_BYTES)) u_pw (
    .clock  (clock),
    .resetn (resetn),
    .lk     (lk.pw)
  );

  interval_timer #(.TICK_LEN(TICK_LEN)) u_tmr (
    .clock  (clock),
    .resetn (resetn),
    .lk     (lk.tmr)
  );

  function automatic logic [31:0] mergeSel(input logic [31:0] old, input logic [31:0] val,
                                           input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) r[8*i +: 8] = val[8*i +: 8];
    end
    return r;
  endfunction : mergeSel

  // bytes arriving during a conversion are lost on purpose; reset still gets through
  assign byteIn  = fnByteValid && !st_r.convBusy && !busReset;
  assign missionActive = st_r.mph != MS_OFF;
  assign pwOk    = !st_r.pwEn || lk.pwMatch;
  assign dummyIn = byteIn && !fnFirst && st_r.cs == CS_DUMMY && fnByte == DUMMY_BYTE;
  assign startOk = dummyIn && st_r.cmd == CMD_START && !missionActive
                   && st_r.logCleared && pwOk;
  assign stopOk  = dummyIn && st_r.cmd == CMD_STOP && missionActive && pwOk;
  assign wr      = wbCyc && wbStb && wbWe && st_r.ack;

  assign lk.pwByte   = fnByte;
  assign lk.pwExpect = st_r.pw;
  assign lk.tmrRun   = st_r.mph == MS_DELAY || st_r.mph == MS_FIRST || st_r.mph == MS_RUN;

  always_comb begin
    logic startConv;
    logic cntThis;
    logic logThis;
    startConv     = 1'b0;
    cntThis       = 1'b0;
    logThis       = 1'b0;
    st_nxt           = st_r;
    st_nxt.convStart = 1'b0;
    st_nxt.logWrite  = 1'b0;
    st_nxt.uptime    = st_r.uptime + 32'h1;
    st_nxt.dqSync    = {st_r.dqSync[0], dqIn};
    lk.pwClear    = 1'b0;
    lk.pwValid    = 1'b0;
    lk.tmrLoad    = 1'b0;
    lk.tmrTicks   = st_r.period;

    // command bytes
    if (busReset) begin
      st_nxt.cs  = CS_IDLE;
      st_nxt.nb  = '0;
      lk.pwClear = 1'b1;
    end else if (byteIn && fnFirst && st_r.cs != CS_MUTE) begin
      st_nxt.cmd = fnByte;
      st_nxt.nb  = '0;
      lk.pwClear = 1'b1;
      case (fnByte)
        CMD_FORCE: st_nxt.cs = missionActive ? CS_MUTE : CS_FORCE_FF;
        CMD_START: st_nxt.cs = CS_PW;
        CMD_STOP:  st_nxt.cs = CS_PW;
        default:   st_nxt.cs = CS_IDLE;
      endcase
    end else if (byteIn && !fnFirst) begin
      case (st_r.cs)
        CS_PW: begin
          lk.pwValid = 1'b1;
          st_nxt.nb  = st_r.nb + 4'h1;
          if (st_r.nb == PW_LAST) st_nxt.cs = CS_DUMMY;
        end
        CS_FORCE_FF: begin
          if (fnByte == DUMMY_BYTE) begin
            startConv = 1'b1;
            st_nxt.cs = CS_IDLE;
          end else begin
            st_nxt.cs = CS_MUTE;
          end
        end
        CS_DUMMY: st_nxt.cs = (startOk || stopOk) ? CS_IDLE : CS_MUTE;
        default: st_nxt.cs = st_r.cs;
      endcase
    end

    // software clear of the awaiting flag only once the wait is over
    if (wr && wbAdr == REG_STATUS && wbSel[0] && wbDatW[STAT_WAIT]
        && st_r.mph != MS_WAIT_ALARM) begin
      st_nxt.awaiting = 1'b0;
    end

    // settings writes, refused during a mission
    if (wr && !missionActive) begin
      case (wbAdr)
        REG_CTRL: begin
          if (wbSel[0]) begin
            st_nxt.pwEn = wbDatW[CTRL_PW_EN];
            st_nxt.alarmStart = wbDatW[CTRL_ALARM_START];
          end
        end
        REG_PW_LO:  st_nxt.pw[31:0]  = mergeSel(st_r.pw[31:0], wbDatW, wbSel);
        REG_PW_HI:  st_nxt.pw[63:32] = mergeSel(st_r.pw[63:32], wbDatW, wbSel);
        REG_DELAY:  st_nxt.delay     = mergeSel(st_r.delay, wbDatW, wbSel);
        REG_PERIOD: st_nxt.period    = mergeSel(st_r.period, wbDatW, wbSel);
        default:    st_nxt.pwEn      = st_r.pwEn;
      endcase
    end

    // mission sequencing
    case (st_r.mph)
      MS_OFF: begin
        if (startOk) begin
          st_nxt.mph        = MS_DELAY;
          st_nxt.logCleared = 1'b0;
          st_nxt.count      = '0;
          lk.tmrLoad        = 1'b1;
          lk.tmrTicks       = st_r.delay;
        end
      end
      MS_DELAY: begin
        if (lk.tmrExpire && st_r.alarmStart) begin
          st_nxt.mph      = MS_WAIT_ALARM;
          st_nxt.awaiting = 1'b1;
        end else if (lk.tmrExpire) begin
          st_nxt.mph = MS_RUN;
          startConv  = 1'b1;
          cntThis    = 1'b1;
          logThis    = 1'b1;
          lk.tmrLoad = 1'b1;
        end
      end
      MS_WAIT_ALARM: begin
        if (tempAlarm && !st_r.convBusy) begin
          st_nxt.mph      = MS_FIRST;
          st_nxt.awaiting = 1'b0;
          startConv       = 1'b1;
          logThis         = 1'b1;
          lk.tmrLoad      = 1'b1;
        end
      end
      MS_FIRST: begin
        if (lk.tmrExpire) begin
          st_nxt.mph   = MS_RUN;
          st_nxt.stamp = st_r.uptime;
          startConv    = 1'b1;
          cntThis      = 1'b1;
          logThis      = 1'b1;
          lk.tmrLoad   = 1'b1;
        end
      end
      MS_RUN: begin
        if (lk.tmrExpire) begin
          startConv  = 1'b1;
          cntThis    = 1'b1;
          logThis    = 1'b1;
          lk.tmrLoad = 1'b1;
        end
      end
      default: st_nxt.mph = MS_OFF;
    endcase

    // stop leaves the awaiting flag as it is
    if (stopOk) st_nxt.mph = MS_OFF;

    // set wins over the clear at mission start
    if (clearDone) st_nxt.logCleared = 1'b1;

    // conversion: a sample due while busy is skipped rather than queued
    if (startConv && !st_r.convBusy) begin
      st_nxt.convBusy  = 1'b1;
      st_nxt.convStart = 1'b1;
      st_nxt.convCnt   = '0;
      st_nxt.countIt   = cntThis;
      st_nxt.logIt     = logThis;
    end else if (st_r.convBusy) begin
      if (sensorValid) begin
        st_nxt.convBusy = 1'b0;
        st_nxt.temp     = sensorData;
        st_nxt.logWrite = st_r.logIt;
        if (st_r.countIt) st_nxt.count = st_r.count + 32'h1;
      end else if (st_r.convCnt == 32'(CONV_LIMIT - 1)) begin
        st_nxt.convBusy = 1'b0;
      end else begin
        st_nxt.convCnt = st_r.convCnt + 32'h1;
      end
    end

    // bus slave: one wait state, read data caught with the ack
    st_nxt.ack = wbCyc && wbStb && !st_r.ack;
    if (st_nxt.ack) begin
      case (wbAdr)
        REG_CTRL:   st_nxt.rdata = {30'h0, st_r.alarmStart, st_r.pwEn};
        REG_STATUS: st_nxt.rdata = {27'h0, st_r.cs == CS_MUTE, st_r.convBusy,
                                    st_r.logCleared, st_r.awaiting, missionActive};
        REG_PW_LO:  st_nxt.rdata = 32'h0;
        REG_PW_HI:  st_nxt.rdata = 32'h0;
        REG_DELAY:  st_nxt.rdata = st_r.delay;
        REG_PERIOD: st_nxt.rdata = st_r.period;
        REG_TEMP:   st_nxt.rdata = {16'h0, st_r.temp};
        REG_COUNT:  st_nxt.rdata = st_r.count;
        REG_STAMP:  st_nxt.rdata = st_r.stamp;
        default:    st_nxt.rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) st_r <= CTL_RST;
    else         st_r <= st_nxt;
  end

  assign wbAck         = st_r.ack;
  assign wbDatR        = st_r.rdata;
  assign convStart     = st_r.convStart;
  assign logWrite      = st_r.logWrite;
  assign logData       = st_r.temp;
  assign accessBlocked = st_r.convBusy;
  assign pagesWritable = !missionActive;
  assign awaitingAlarm = st_r.awaiting;
  assign dqSample      = st_r.dqSync[1];
  assign dqOut         = 1'b0;
  // released line reads as ones, so crc and data come out all ones
  assign dqOen = !(presencePull || (slotPullLow && st_r.cs != CS_MUTE
                                    && !st_r.convBusy));

  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  sequence s_forceReq;
    byteIn && fnFirst && fnByte == CMD_FORCE && st_r.cs != CS_MUTE;
  endsequence
  sequence s_alarmTaken;
    st_r.mph == MS_WAIT_ALARM && tempAlarm && !st_r.convBusy;
  endsequence

  property p_mute_release;
    st_r.cs == CS_MUTE && !presencePull |-> dqOen;
  endproperty
  a_mute_release: assert property (p_mute_release)
    else $error("muted device drives the line");

  property p_busy_release;
    st_r.convBusy && !presencePull |-> dqOen
      && ($stable(st_r.cs) || !$past(st_r.convBusy) || $past(busReset));
  endproperty
  a_busy_release: assert property (p_busy_release)
    else $error("line driven or command moved during sampling");

  property p_force_refused;
    s_forceReq ##0 missionActive |=> st_r.cs == CS_MUTE && !st_r.convStart;
  endproperty
  a_force_refused: assert property (p_force_refused)
    else $error("forced conversion accepted during a mission");

  property p_force_go;
    st_r.cs == CS_FORCE_FF && byteIn && !fnFirst && fnByte == DUMMY_BYTE
      |=> st_r.convStart && st_r.convBusy ##1 !st_r.convStart;
  endproperty
  a_force_go: assert property (p_force_go)
    else $error("dummy byte did not start one conversion");

  property p_conv_bound;
    st_r.convBusy && st_r.convCnt == 32'(CONV_LIMIT - 1) && !sensorValid |=> !st_r.convBusy;
  endproperty
  a_conv_bound: assert property (p_conv_bound)
    else $error("conversion outlived its limit");

  property p_result;
    st_r.convBusy && sensorValid |=> st_r.temp == $past(sensorData) && !st_r.convBusy;
  endproperty
  a_result: assert property (p_result)
    else $error("conversion result not stored");

  property p_start_needs_clear;
    dummyIn && st_r.cmd == CMD_START && !st_r.logCleared && !missionActive
      |=> st_r.cs == CS_MUTE && st_r.mph == MS_OFF;
  endproperty
  a_start_needs_clear: assert property (p_start_needs_clear)
    else $error("mission started on an uncleared log");

  property p_stop_keeps_wait;
    stopOk |=> !missionActive && pagesWritable && st_r.awaiting == $past(st_r.awaiting);
  endproperty
  a_stop_keeps_wait: assert property (p_stop_keeps_wait)
    else $error("stop did not end the mission cleanly");

  property p_wait_flag;
    st_r.mph == MS_WAIT_ALARM |-> st_r.awaiting;
  endproperty
  a_wait_flag: assert property (p_wait_flag)
    else $error("awaiting flag low while waiting for alarm");

  property p_first_uncounted;
    s_alarmTaken ##0 !stopOk |=> st_r.mph == MS_FIRST && st_r.convStart
      && st_r.count == $past(st_r.count) && !st_r.countIt;
  endproperty
  a_first_uncounted: assert property (p_first_uncounted)
    else $error("first alarm sample counted or not taken");

  property p_pages_locked;
    wr && missionActive && wbAdr == REG_PERIOD |=> $stable(st_r.period);
  endproperty
  a_pages_locked: assert property (p_pages_locked)
    else $error("settings written during a mission");

  property p_clear_flag;
    clearDone |=> st_r.logCleared;
  endproperty
  a_clear_flag: assert property (p_clear_flag)
    else $error("log cleared flag not set");
endmodule : mission_control

//--- design/mc_pkg.sv
// constants, register map and state types for the mission control block
// assumes one 50 MHz clock shared by the link layer, the sensor and the bus slave
package mc_pkg;
  localparam int CLOCK_HZ      = 50_000_000;
  localparam int CONV_MAX_MS   = 600;
  localparam int CONV_CYCLES   = CONV_MAX_MS * (CLOCK_HZ / 1000);
  localparam int TICK_MS       = 1;
  localparam int TICK_CYCLES   = TICK_MS * (CLOCK_HZ / 1000);

  // function command codes and the dummy byte
  localparam logic [7:0] CMD_FORCE  = 8'h55;
  localparam logic [7:0] CMD_START  = 8'hcc;
  localparam logic [7:0] CMD_STOP   = 8'h33;
  localparam logic [7:0] DUMMY_BYTE = 8'hff;
  localparam int         PW_BYTES   = 8;
  localparam logic [3:0] PW_LAST    = 4'h7;

  // register byte offsets
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_PW_LO  = 8'h08;
  localparam logic [7:0] REG_PW_HI  = 8'h0c;
  localparam logic [7:0] REG_DELAY  = 8'h10;
  localparam logic [7:0] REG_PERIOD = 8'h14;
  localparam logic [7:0] REG_TEMP   = 8'h18;
  localparam logic [7:0] REG_COUNT  = 8'h1c;
  localparam logic [7:0] REG_STAMP  = 8'h20;

  // field positions
  localparam int CTRL_PW_EN       = 0;
  localparam int CTRL_ALARM_START = 1;
  localparam int STAT_ACTIVE      = 0;
  localparam int STAT_WAIT        = 1;
  localparam int STAT_CLR         = 2;
  localparam int STAT_BUSY        = 3;
  localparam int STAT_MUTE        = 4;

  // values after reset
  localparam logic [31:0] PERIOD_RST = 32'h0000_03e8;
  localparam logic [31:0] DELAY_RST  = 32'h0000_0000;

  typedef enum logic [2:0] {CS_IDLE, CS_PW, CS_DUMMY, CS_FORCE_FF, CS_MUTE} cmd_state_t;
  typedef enum logic [2:0] {MS_OFF, MS_DELAY, MS_WAIT_ALARM, MS_FIRST, MS_RUN} mission_t;
endpackage : mc_pkg

//--- design/mc_link_if.sv
// signals between the mission controller and its password and timer helpers
// assumes all parties run on the same clock
`timescale 1ns/1ps
interface mc_link_if;
  logic        pwClear;
  logic        pwValid;
  logic [7:0]  pwByte;
  logic [63:0] pwExpect;
  logic        pwMatch;
  logic        tmrLoad;
  logic [31:0] tmrTicks;
  logic        tmrRun;
  logic        tmrExpire;
  modport ctl (output pwClear, pwValid, pwByte, pwExpect, tmrLoad, tmrTicks, tmrRun,
               input pwMatch, tmrExpire);
  modport pw  (input pwClear, pwValid, pwByte, pwExpect, output pwMatch);
  modport tmr (input tmrLoad, tmrTicks, tmrRun, output tmrExpire);
endinterface : mc_link_if

//--- design/pw_matcher.sv
// collects password bytes, first byte lowest, and compares with the stored one
// assumes the controller clears it at each new command
`timescale 1ns/1ps
module pw_matcher
  import mc_pkg::*;
#(
  parameter int BYTES = PW_BYTES
) (
  // clock and reset
  input  wire logic clock,
  input  wire logic resetn,
  // link to controller
  mc_link_if.pw     lk
);
  typedef struct packed {
    logic [63:0] shift;
    logic [3:0]  cnt;
  } pw_state_t;

  pw_state_t st_r;
  pw_state_t st_nxt;

  initial begin
    if (BYTES != 8) $error("pw_matcher serves 8 password bytes only");
  end

  always_comb begin
    st_nxt = st_r;
    if (lk.pwClear) begin
      st_nxt = '0;
    end else if (lk.pwValid && st_r.cnt != 4'(BYTES)) begin
      st_nxt.shift = {lk.pwByte, st_r.shift[63:8]};
      st_nxt.cnt   = st_r.cnt + 4'h1;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) st_r <= '0;
    else         st_r <= st_nxt;
  end

  // a short password never matches
  assign lk.pwMatch = (st_r.cnt == 4'(BYTES)) && (st_r.shift == lk.pwExpect);
endmodule : pw_matcher

//--- design/interval_timer.sv
// counts a number of ticks and pulses expire once when they have passed
// assumes load restarts it; run low freezes it
`timescale 1ns/1ps
module interval_timer
  import mc_pkg::*;
#(
  parameter int TICK_LEN = TICK_CYCLES
) (
  // clock and reset
  input  wire logic clock,
  input  wire logic resetn,
  // link to controller
  mc_link_if.tmr    lk
);
  typedef struct packed {
    logic [31:0] pre;
    logic [31:0] left;
    logic        armed;
    logic        fire;
  } tmr_state_t;

  tmr_state_t st_r;
  tmr_state_t st_nxt;

  initial begin
    if (TICK_LEN < 1) $error("interval_timer needs a tick of at least one cycle");
  end

  always_comb begin
    st_nxt      = st_r;
    st_nxt.fire = 1'b0;
    if (lk.tmrLoad) begin
      st_nxt.pre   = '0;
      st_nxt.left  = lk.tmrTicks;
      st_nxt.armed = 1'b1;
    end else if (lk.tmrRun && st_r.armed) begin
      if (st_r.left == '0) begin
        st_nxt.fire  = 1'b1;
        st_nxt.armed = 1'b0;
      end else if (st_r.pre == 32'(TICK_LEN - 1)) begin
        st_nxt.pre  = '0;
        st_nxt.left = st_r.left - 32'h1;
      end else begin
        st_nxt.pre = st_r.pre + 32'h1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) st_r <= '0;
    else         st_r <= st_nxt;
  end

  assign lk.tmrExpire = st_r.fire;
endmodule : interval_timer

//--- verification/fn_master.sv
// function-byte source in place of the bus master and its slot layer
// assumes the testbench calls its tasks from the clock domain
`timescale 1ns/1ps
module fn_master (
  // clock
  input  wire logic       clock,
  // bytes to the device
  output logic            fnByteValid,
  output logic      [7:0] fnByte,
  output logic            fnFirst,
  output logic            busReset
);
  initial begin
    fnByteValid = 1'b0;
    fnByte      = 8'hff;
    fnFirst     = 1'b0;
    busReset    = 1'b0;
  end
  // a released byte shows its inverse so stale data never looks valid
  task automatic send(input logic [7:0] b, input logic f);
    @(posedge clock);
    fnByteValid <= 1'b1;
    fnByte      <= b;
    fnFirst     <= f;
    @(posedge clock);
    fnByteValid <= 1'b0;
    fnFirst     <= 1'b0;
    fnByte      <= ~b;
  endtask : send
  task automatic cmd(input logic [7:0] code, input logic [63:0] pw);
    send(code, 1'b1);
    for (int i = 0; i < 8; i++) begin
      send(pw[8*i +: 8], 1'b0);
    end
    send(8'hff, 1'b0);
  endtask : cmd
  task automatic reset_bus();
    @(posedge clock);
    busReset <= 1'b1;
    @(posedge clock);
    busReset <= 1'b0;
  endtask : reset_bus
endmodule : fn_master

//--- verification/testbench.sv
// self-checking bench for the mission control block
// assumes a pull-up on the data line and a sensor that answers promptly when enabled
`timescale 1ns/1ps
module testbench;
  import mc_pkg::*;
  logic clock = 1'b0, resetn = 1'b0, wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0;
  logic [7:0]  wbAdr = 8'h00;
  logic [31:0] wbDatW = 32'h0, wbDatR, q;
  logic wbAck, fnByteValid, fnFirst, busReset, dqOut, dqOen, dqSample, convStart;
  logic [7:0]  fnByte;
  logic [15:0] logData;
  logic slotPullLow = 1'b0, sensorValid = 1'b0, tempAlarm = 1'b0, clearDone = 1'b0;
  logic sensOn = 1'b0, logWrite, accessBlocked, pagesWritable, missionActive, awaitingAlarm;
  int   errCount = 0, checkCount = 0;
  always #10 clock = ~clock;
  always @(posedge clock) sensorValid <= convStart & sensOn;
  fn_master fm (.clock(clock), .fnByteValid(fnByteValid), .fnByte(fnByte),
    .fnFirst(fnFirst), .busReset(busReset));
  mission_control #(.CONV_LIMIT(50), .TICK_LEN(4)) u_dut (.clock(clock), .resetn(resetn),
    .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(4'hf),
    .wbDatW(wbDatW), .wbDatR(wbDatR), .wbAck(wbAck), .fnByteValid(fnByteValid),
    .fnByte(fnByte), .fnFirst(fnFirst), .busReset(busReset), .slotPullLow(slotPullLow),
    .presencePull(1'b0), .dqIn(dqOen), .dqOut(dqOut), .dqOen(dqOen), .dqSample(dqSample),
    .convStart(convStart), .sensorValid(sensorValid), .sensorData(16'ha5c3),
    .tempAlarm(tempAlarm), .clearDone(clearDone), .logWrite(logWrite), .logData(logData),
    .accessBlocked(accessBlocked), .pagesWritable(pagesWritable),
    .missionActive(missionActive), .awaitingAlarm(awaitingAlarm));
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checkCount, errCount);
    if (errCount == 0 && checkCount > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : report_and_stop
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checkCount++;
    if (g !== e) begin
      errCount++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask : tick
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clock);
    wbCyc  <= 1'b1;
    wbStb  <= 1'b1;
    wbWe   <= we;
    wbAdr  <= a;
    wbDatW <= d;
    for (k = 0; k < 20; k++) begin
      @(posedge clock);
      if (wbAck === 1'b1) break;
    end
    q = wbDatR;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    if (k == 20) begin
      errCount++;
      report_and_stop();
    end
  endtask : wb
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk("register read", e, q);
  endtask : rd
  task automatic pull(input logic e);
    slotPullLow <= 1'b1;
    tick(1);
    chk("dqOen", {31'h0, e}, {31'h0, dqOen});
    slotPullLow <= 1'b0;
  endtask : pull
  task automatic wait_log();
    for (int k = 0; k < 40 && logWrite !== 1'b1; k++) @(posedge clock);
    chk("logWrite", 32'h1, {31'h0, logWrite});
    if (logWrite !== 1'b1) report_and_stop();
  endtask : wait_log
  task automatic wait_busy();
    for (int k = 0; k < 5000 && accessBlocked !== 1'b1; k++) @(posedge clock);
    chk("accessBlocked", 32'h1, {31'h0, accessBlocked});
    if (accessBlocked !== 1'b1) report_and_stop();
  endtask : wait_busy
  task automatic clear_log();
    clearDone <= 1'b1;
    tick(1);
    clearDone <= 1'b0;
    tick(1);
  endtask : clear_log
  task automatic t_reset();
    rd(REG_STATUS, 32'h0);
    rd(8'h40, 32'h0);
    chk("pagesWritable", 32'h1, {31'h0, pagesWritable});
    chk("dqOut", 32'h0, {31'h0, dqOut});
    chk("dqSample", 32'h1, {31'h0, dqSample});
    pull(1'b0);
  endtask : t_reset
  task automatic t_force();
    fm.send(CMD_FORCE, 1'b1);
    fm.send(DUMMY_BYTE, 1'b0);
    tick(1);
    chk("convStart", 32'h1, {31'h0, convStart});
    pull(1'b1);
    tick(38);
    chk("busy kept", 32'h1, {31'h0, accessBlocked});
    tick(20);
    chk("busy ended", 32'h0, {31'h0, accessBlocked});
    sensOn = 1'b1;
    fm.send(CMD_FORCE, 1'b1);
    fm.send(DUMMY_BYTE, 1'b0);
    tick(6);
    rd(REG_TEMP, 32'h0000_a5c3);
  endtask : t_force
  task automatic t_missions();
    fm.cmd(CMD_START, 64'h0);
    tick(1);
    rd(REG_STATUS, 32'h10);
    pull(1'b1);
    fm.reset_bus();
    clear_log();
    rd(REG_STATUS, 32'h4);
    fm.cmd(CMD_START, 64'h0);
    tick(1);
    chk("mission", 32'h1, {31'h0, missionActive});
    wait_log();
    chk("logData", 32'h0000_a5c3, {16'h0, logData});
    rd(REG_COUNT, 32'h1);
    wb(1'b1, REG_PERIOD, 32'h7);
    rd(REG_PERIOD, PERIOD_RST);
    fm.send(CMD_FORCE, 1'b1);
    fm.send(DUMMY_BYTE, 1'b0);
    tick(1);
    chk("no conv", 32'h0, {31'h0, convStart});
    fm.reset_bus();
    fm.cmd(CMD_STOP, 64'h0);
    tick(1);
    chk("stopped", 32'h0, {31'h0, missionActive});
    chk("writable", 32'h1, {31'h0, pagesWritable});
    fm.cmd(CMD_STOP, 64'h0);
    tick(1);
    rd(REG_STATUS, 32'h10);
    fm.reset_bus();
  endtask : t_missions
  task automatic t_alarm();
    wb(1'b1, REG_CTRL, 32'h2);
    clear_log();
    fm.cmd(CMD_START, 64'h0);
    tick(3);
    chk("waiting", 32'h1, {31'h0, awaitingAlarm});
    wb(1'b1, REG_STATUS, 32'h2);
    chk("wait kept", 32'h1, {31'h0, awaitingAlarm});
    tempAlarm <= 1'b1;
    wait_log();
    tick(2);
    chk("alarm seen", 32'h0, {31'h0, awaitingAlarm});
    tempAlarm <= 1'b0;
    rd(REG_COUNT, 32'h0);
    // a silent sensor keeps the next sample busy for the whole limit
    sensOn = 1'b0;
    wait_busy();
    fm.cmd(CMD_STOP, 64'h0);
    rd(REG_STATUS, 32'h9);
    tick(40);
    fm.reset_bus();
    fm.cmd(CMD_STOP, 64'h0);
    tick(1);
    chk("stop retried", 32'h0, {31'h0, missionActive});
    chk("wait unchanged", 32'h0, {31'h0, awaitingAlarm});
  endtask : t_alarm
  initial begin
    repeat (10) @(posedge clock);
    resetn <= 1'b1;
    t_reset();
    t_force();
    t_missions();
    t_alarm();
    report_and_stop();
  end
endmodule : testbench
